// ### sim/testbench.sv
// Self-checking bench for the execution and exception state word
`timescale 1ns/10ps
module testbench
    import esw_pkg::*;
();
    // ----------------------------------------
    // Signals and tables
    // ----------------------------------------
    localparam int KE = 0;
    localparam int KR = 1;
    localparam int KB = 2;
    localparam int KM = 3;
    localparam int KC = 4;
    localparam int KS = 5;
    localparam int KX = 6;
    typedef struct {
        int kind;
        logic [31:0] arg;
        logic [5:0] num;
        logic [31:0] mask;
        logic [31:0] exp;
        logic [7:0] amask;
        logic [7:0] aexp;
    } esw_row_s;
    logic hclk;
    logic hresetn;
    logic hsel;
    logic [11:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    wire logic hready;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    esw_core_ev_s core_ev;
    esw_core_ans_s core_ans;
    esw_core_ans_s last_ans;
    logic exn_reserved;
    logic handler;
    logic [31:0] d;
    logic [31:0] dp;
    int miscompares = 0;
    int cmp_count = 0;
    // Masks keep out bits 31:27, which this block does not own
    esw_row_s rows[7] = '{
        '{KE, 32'h0000_0101, 6'h10, 32'h07ff_ffff, 32'h0100_0010, 8'h00, 8'h00},
        '{KM, 32'h0000_0005, 6'h00, 32'h07ff_fc00, 32'h0100_5000, 8'h00, 8'h00},
        '{KB, 32'h0000_2000, 6'h00, 32'h0100_0000, 32'h0000_0000, 8'h00, 8'h00},
        '{KB, 32'h0000_2001, 6'h00, 32'h0100_0000, 32'h0100_0000, 8'h00, 8'h00},
        '{KR, 32'h0000_7000, 6'h00, 32'h0700_fc00, 32'h0000_7000, 8'hff, 8'h2e},
        '{KE, 32'h0000_0000, 6'h03, 32'h0100_003f, 32'h0000_0003, 8'h00, 8'h00},
        '{KE, 32'h0000_0001, 6'h3b, 32'h0100_003f, 32'h0100_003b, 8'h00, 8'h00}
    };
    logic [5:0] codes[8] = '{6'h00, 6'h01, 6'h02, 6'h0f, 6'h10, 6'h3b, 6'h3c, 6'h3f};

    // Zero wait state slave drives its own ready back
    assign hready = hreadyout;

    esw_state_word esw_state_word_i (
        .hclk(hclk),
        .hresetn(hresetn),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hsize(hsize),
        .hready(hready),
        .hwdata(hwdata),
        .hrdata(hrdata),
        .hreadyout(hreadyout),
        .hresp(hresp),
        .core_ev(core_ev),
        .core_ans(core_ans),
        .exn_reserved(exn_reserved)
    );

    initial
    begin
        hclk = 1'b0;
        forever #2 hclk = ~hclk;
    end

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        cmp_count++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("[ERR] %0t %s: got %h expected %h", $time, what, seen, exp);
        end
    endtask

    task automatic ahb(input logic [11:0] a, input logic w, input logic [31:0] wd,
                       output logic [31:0] rd);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'b10;
        hwrite <= w;
        hsize <= 3'b010;
        do @(posedge hclk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge hclk); while (hready !== 1'b1);
        rd = hrdata;
    endtask

    task automatic rd_reg(input logic [11:0] a, output logic [31:0] v);
        ahb(a, 1'b0, 32'h0, v);
    endtask

    task automatic wr_reg(input logic [11:0] a, input logic [31:0] v);
        logic [31:0] unused;
        ahb(a, 1'b1, v, unused);
    endtask

    // One-cycle event pulse; answer sampled once it has settled
    task automatic core_event(input int kind, input logic [31:0] arg, input logic [5:0] num);
        esw_core_ev_s ev;
        ev = '0;
        ev.in_handler = handler;
        ev.target_addr = arg;
        ev.vector_value = arg;
        ev.stacked_status_word = arg;
        ev.next_reg_index = arg[3:0];
        ev.cond_block_bits = arg[7:0];
        ev.exc_number = num;
        ev.exc_entry = (kind == KE);
        ev.exc_return = (kind == KR);
        ev.xchg_branch = (kind == KB);
        ev.multi_interrupted = (kind == KM);
        ev.cond_block_start = (kind == KC);
        ev.cond_block_step = (kind == KS);
        ev.exec_attempt = (kind == KX);
        @(posedge hclk);
        core_ev <= ev;
        ev = '0;
        ev.in_handler = handler;
        @(posedge hclk);
        core_ev <= ev;
        @(negedge hclk);
        last_ans = core_ans;
    endtask

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // ----------------------------------------
    // Sequence
    // ----------------------------------------
    initial
    begin
        hsel = 1'b0;
        haddr = 12'h000;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'b010;
        hwdata = 32'h0;
        core_ev = '0;
        handler = 1'b0;
        hresetn = 1'b0;
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        // Release passes a two-stage synchroniser inside the block
        repeat (2) @(posedge hclk);
        rd_reg(PSW_ADDR, d);
        check(d & 32'h07ff_ffff, 32'h0100_0000, "reset word");
        check({23'h0, exn_reserved, core_ans}, 32'h0, "reset answers");
        check({30'h0, hresp, hreadyout}, 32'h1, "bus response");
        $display("test reset finished");
        foreach (rows[i])
        begin
            core_event(rows[i].kind, rows[i].arg, rows[i].num);
            rd_reg(PSW_ADDR, d);
            check(d & rows[i].mask, rows[i].exp, "event word");
            check({24'h0, last_ans & rows[i].amask}, {24'h0, rows[i].aexp}, "resume");
        end
        $display("test events finished");
        foreach (codes[i])
        begin
            core_event(KE, 32'h1, codes[i]);
            rd_reg(INTR_VIEW_ADDR, d);
            check(d, {26'h0, codes[i]}, "exception view");
            check({31'h0, exn_reserved}, {31'h0, codes[i] == 6'h01 || codes[i] >= 6'h3c},
                  "reserved code");
            rd_reg(EXEC_VIEW_ADDR, d);
            check(d & 32'hf8ff_03ff, 32'h0, "exec view");
        end
        $display("test views finished");
        rd_reg(PSW_ADDR, dp);
        wr_reg(PSW_ADDR, 32'hffff_ffff);
        rd_reg(PSW_ADDR, d);
        check(d, dp, "read only word");
        check(d & 32'h00ff_03c0, 32'h0, "reserved bits");
        rd_reg(12'h100, d);
        check(d, 32'h0, "unmapped read");
        $display("test access finished");
        // State bit set: execution must not fault
        core_event(KX, 32'h0, 6'h00);
        check({31'h0, last_ans.exec_fault}, 32'h0, "no fault");
        core_event(KB, 32'h0000_2000, 6'h00);
        core_event(KX, 32'h0, 6'h00);
        check({31'h0, last_ans.exec_fault}, 32'h1, "fault");
        rd_reg(STAT_ADDR, d);
        check(d & 32'h3, 32'h1, "fault flag");
        wr_reg(CTRL_ADDR, 32'h1);
        rd_reg(STAT_ADDR, d);
        check(d & 32'h3, 32'h0, "fault cleared");
        handler = 1'b1;
        core_event(KX, 32'h0, 6'h00);
        repeat (3) @(posedge hclk);
        @(negedge hclk);
        check({31'h0, core_ans.lockup}, 32'h1, "lockup held");
        rd_reg(STAT_ADDR, d);
        check(d & 32'h3, 32'h2, "lockup flag");
        wr_reg(CTRL_ADDR, 32'h2);
        rd_reg(STAT_ADDR, d);
        check(d & 32'h3, 32'h0, "lockup cleared");
        handler = 1'b0;
        $display("test fault finished");
        core_event(KB, 32'h0000_2001, 6'h00);
        // Block activity reaches the core one cycle after the step counter
        core_event(KC, 32'h0000_0001, 6'h00);
        @(negedge hclk);
        check({31'h0, core_ans.cond_active}, 32'h1, "block open");
        repeat (3) core_event(KS, 32'h0, 6'h00);
        @(negedge hclk);
        check({31'h0, core_ans.cond_active}, 32'h1, "block third step");
        rd_reg(STAT_ADDR, d);
        check(d & 32'h8, 32'h8, "in block flag");
        core_event(KS, 32'h0, 6'h00);
        @(negedge hclk);
        check({31'h0, core_ans.cond_active}, 32'h0, "block closed");
        $display("test block finished");
        // Second reset in mid-run with suspended state held
        core_event(KE, 32'h1, 6'h15);
        core_event(KM, 32'h3, 6'h00);
        rd_reg(STAT_ADDR, d);
        check(d & 32'h4, 32'h4, "suspend flag");
        @(posedge hclk);
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (2) @(posedge hclk);
        rd_reg(PSW_ADDR, d);
        check(d & 32'h07ff_ffff, 32'h0100_0000, "second reset");
        rd_reg(STAT_ADDR, d);
        check(d, 32'h0, "second reset status");
        $display("test rereset finished");
        finish_test();
    end

    // Whole run is well under a thousand cycles
    initial
    begin
        #80000;
        miscompares++;
        $display("[ERR] %0t watchdog expired", $time);
        finish_test();
    end
endmodule

// ### src/esw_ahb_slave.sv
// AHB-Lite register slave for the state word block
`timescale 1ns/10ps
module esw_ahb_slave
    import esw_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [11:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    output logic wr_stb,
    output logic [11:0] wr_addr,
    output logic [31:0] wr_data,
    input wire logic [31:0] rd_psw,
    input wire logic [31:0] rd_exec,
    input wire logic [31:0] rd_intr,
    input wire logic [31:0] rd_stat
);
    logic dp_write;
    logic [11:0] dp_addr;
    logic take;

    assign take = hsel & hready & htrans[1];

    // ----------------------------------------
    // Address phase capture
    // ----------------------------------------
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            dp_write <= 1'b0;
            dp_addr <= 12'h000;
        end
        else
        begin
            dp_write <= take & hwrite;
            dp_addr <= take ? haddr : dp_addr;
        end
    end

    // ----------------------------------------
    // Read data, registered at address phase
    // ----------------------------------------
    // Unmapped reads return zero; views expose only their own fields
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            hrdata <= 32'h0000_0000;
        else if (take && !hwrite)
        begin
            unique case (haddr)
                PSW_ADDR: hrdata <= rd_psw;
                EXEC_VIEW_ADDR: hrdata <= rd_exec;
                INTR_VIEW_ADDR: hrdata <= rd_intr;
                STAT_ADDR: hrdata <= rd_stat;
                default: hrdata <= 32'h0000_0000;
            endcase
        end
    end

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign wr_stb = dp_write;
    assign wr_addr = dp_addr;
    assign wr_data = hwdata;
endmodule

// ### src/esw_pkg.sv
// Constants and types for the execution and exception state word
package esw_pkg;
    // ----------------------------------------
    // Register map (byte addresses)
    // ----------------------------------------
    localparam logic [11:0] PSW_ADDR = 12'h000;
    localparam logic [11:0] EXEC_VIEW_ADDR = 12'h004;
    localparam logic [11:0] INTR_VIEW_ADDR = 12'h008;
    localparam logic [11:0] CTRL_ADDR = 12'h00c;
    localparam logic [11:0] STAT_ADDR = 12'h010;
    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int ISB_POS = 24;
    localparam int UPR_LO = 25;
    localparam int UPR_HI = 26;
    localparam int LWR_LO = 10;
    localparam int LWR_HI = 15;
    localparam int IDX_LO = 12;
    localparam int IDX_HI = 15;
    localparam int EXN_LO = 0;
    localparam int EXN_HI = 5;
    // ----------------------------------------
    // Reset values and codes
    // ----------------------------------------
    localparam logic ISB_RESET = 1'h1;
    localparam logic [7:0] CSTATE_RESET = 8'h00;
    localparam logic [5:0] EXN_RESET = 6'h00;
    localparam logic [5:0] EXN_SYS_LO = 6'h02;
    localparam logic [5:0] EXN_SYS_HI = 6'h0f;
    localparam logic [5:0] EXN_IRQ_LO = 6'h10;
    localparam logic [5:0] EXN_IRQ_HI = 6'h3b;
    localparam logic [3:0] COND_BLOCK_MAX = 4'h4;
    // Control register bits
    localparam int CTRL_FAULT_CLR = 0;
    localparam int CTRL_LOCK_CLR = 1;
    // Status register bits
    localparam int STAT_FAULT = 0;
    localparam int STAT_LOCK = 1;
    localparam int STAT_RESUME = 2;
    localparam int STAT_INBLOCK = 3;

    typedef enum logic [1:0] {
        ESW_ST_RUN,
        ESW_ST_SUSPENDED,
        ESW_ST_LOCKUP
    } esw_state_e;

    // Core event carrier
    typedef struct packed {
        logic xchg_branch;
        logic [31:0] target_addr;
        logic exc_entry;
        logic [31:0] vector_value;
        logic [5:0] exc_number;
        logic exc_return;
        logic [31:0] stacked_status_word;
        logic multi_interrupted;
        logic [3:0] next_reg_index;
        logic cond_block_start;
        logic [7:0] cond_block_bits;
        logic cond_block_step;
        logic exec_attempt;
        logic in_handler;
    } esw_core_ev_s;

    // Answer to the core
    typedef struct packed {
        logic exec_fault;
        logic lockup;
        logic resume_valid;
        logic [3:0] resume_index;
        logic cond_active;
    } esw_core_ans_s;
endpackage

// ### src/esw_state_word.sv
// Execution and exception state word of the core
`timescale 1ns/10ps
module esw_state_word
    import esw_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [11:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire esw_core_ev_s core_ev,
    output esw_core_ans_s core_ans,
    output logic exn_reserved
);
    // ----------------------------------------
    // State
    // ----------------------------------------
    logic isb;
    logic [7:0] cstate;
    logic [5:0] exn;
    logic fault;
    logic lock;
    logic [2:0] cond_left;
    esw_state_e state;
    logic wr_stb;
    logic [11:0] wr_addr;
    logic [31:0] wr_data;
    logic [31:0] psw;
    logic [31:0] exec_view;
    logic [31:0] intr_view;
    logic [31:0] stat_word;
    logic bad_exec;
    logic [1:0] rst_sync;
    logic rst_n;

    function automatic logic exn_is_reserved(input logic [5:0] n);
        exn_is_reserved = (n != EXN_RESET) &&
            !((n >= EXN_SYS_LO) && (n <= EXN_SYS_HI)) &&
            !((n >= EXN_IRQ_LO) && (n <= EXN_IRQ_HI));
    endfunction

    // ----------------------------------------
    // Reset synchroniser
    // ----------------------------------------
    // Release is timed to the clock so no flop leaves reset mid-setup
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            rst_sync <= 2'b00;
        else
            rst_sync <= {rst_sync[0], 1'b1};
    end

    assign rst_n = rst_sync[1];

    // ----------------------------------------
    // Register bus
    // ----------------------------------------
    esw_ahb_slave u_bus (
        .hclk(hclk),
        .hresetn(rst_n),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hsize(hsize),
        .hready(hready),
        .hwdata(hwdata),
        .hrdata(hrdata),
        .hreadyout(hreadyout),
        .hresp(hresp),
        .wr_stb(wr_stb),
        .wr_addr(wr_addr),
        .wr_data(wr_data),
        .rd_psw(psw),
        .rd_exec(exec_view),
        .rd_intr(intr_view),
        .rd_stat(stat_word)
    );

    // ----------------------------------------
    // Read views
    // ----------------------------------------
    // reserved read zero
    always_comb
    begin
        psw = 32'h0000_0000;
        psw[ISB_POS] = isb;
        psw[UPR_HI:UPR_LO] = cstate[7:6];
        psw[LWR_HI:LWR_LO] = cstate[5:0];
        psw[EXN_HI:EXN_LO] = exn;
        exec_view = psw & 32'h0700_fc00;
        intr_view = psw & 32'h0000_003f;
    end

    assign stat_word = {28'h0000000, (state == ESW_ST_RUN) && (cond_left != 3'h0),
                        state == ESW_ST_SUSPENDED, lock, fault};

    // ----------------------------------------
    // Instruction-set state bit
    // ----------------------------------------
    always_ff @(posedge hclk or negedge rst_n)
    begin
        if (!rst_n)
            isb <= ISB_RESET;
        else if (core_ev.exc_entry)
            isb <= core_ev.vector_value[0];
        else if (core_ev.exc_return)
            isb <= core_ev.stacked_status_word[ISB_POS];
        else if (core_ev.xchg_branch)
            isb <= core_ev.target_addr[0];
    end

    // ----------------------------------------
    // Execution fault and lockup
    // ----------------------------------------
    assign bad_exec = core_ev.exec_attempt && !isb;

    always_ff @(posedge hclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            fault <= 1'b0;
            lock <= 1'b0;
        end
        else
        begin
            // fault or lockup
            // Set wins over a software clear in the same cycle
            if (bad_exec && !core_ev.in_handler)
                fault <= 1'b1;
            else if (wr_stb && wr_addr == CTRL_ADDR && wr_data[CTRL_FAULT_CLR])
                fault <= 1'b0;
            if (bad_exec && core_ev.in_handler)
                lock <= 1'b1;
            else if (wr_stb && wr_addr == CTRL_ADDR && wr_data[CTRL_LOCK_CLR])
                lock <= 1'b0;
        end
    end

    // ----------------------------------------
    // Resume / conditional block state
    // ----------------------------------------
    always_ff @(posedge hclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cstate <= CSTATE_RESET;
            cond_left <= 3'h0;
            state <= ESW_ST_RUN;
        end
        else if (core_ev.exc_return)
        begin
            cstate <= {core_ev.stacked_status_word[UPR_HI:UPR_LO],
                       core_ev.stacked_status_word[LWR_HI:LWR_LO]};
            state <= ESW_ST_RUN;
        end
        else if (core_ev.multi_interrupted)
        begin
            cstate <= {2'b00, core_ev.next_reg_index, 2'b00};
            cond_left <= 3'h0;
            state <= ESW_ST_SUSPENDED;
        end
        else if (core_ev.cond_block_start)
        begin
            cstate <= core_ev.cond_block_bits;
            cond_left <= COND_BLOCK_MAX[2:0];
        end
        else if (core_ev.cond_block_step && cond_left != 3'h0)
        begin
            // Mask shifts left; block ends when mask drains or on the fourth step
            cond_left <= cond_left - 3'h1;
            if (cstate[3:0] == 4'h8 || cond_left == 3'h1)
            begin
                cstate <= 8'h00;
                cond_left <= 3'h0;
            end
            else
                cstate <= {cstate[7:5], cstate[3:0], 1'b0};
        end
        else if (lock)
            state <= ESW_ST_LOCKUP;
        else if (state == ESW_ST_LOCKUP)
            // Lockup ends once software clears the sticky flag
            state <= ESW_ST_RUN;
    end

    // ----------------------------------------
    // Active exception number
    // ----------------------------------------
    always_ff @(posedge hclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            exn <= EXN_RESET;
            exn_reserved <= 1'b0;
        end
        else if (core_ev.exc_entry)
        begin
            exn <= core_ev.exc_number;
            exn_reserved <= exn_is_reserved(core_ev.exc_number);
        end
        else if (core_ev.exc_return)
        begin
            exn <= core_ev.stacked_status_word[EXN_HI:EXN_LO];
            exn_reserved <= exn_is_reserved(core_ev.stacked_status_word[EXN_HI:EXN_LO]);
        end
    end

    // ----------------------------------------
    // Core answer
    // ----------------------------------------
    always_ff @(posedge hclk or negedge rst_n)
    begin
        if (!rst_n)
            core_ans <= '0;
        else
        begin
            core_ans.exec_fault <= bad_exec && !core_ev.in_handler;
            core_ans.lockup <= lock || (bad_exec && core_ev.in_handler);
            core_ans.resume_valid <= core_ev.exc_return &&
                core_ev.stacked_status_word[UPR_HI:UPR_LO] == 2'b00 &&
                core_ev.stacked_status_word[LWR_HI:IDX_LO] != 4'h0;
            core_ans.resume_index <= core_ev.stacked_status_word[IDX_HI:IDX_LO];
            core_ans.cond_active <= cond_left != 3'h0;
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    // Properties skip reset; reset values are checked by the bench over the bus and at the core ports
    a_vector_load: assert property (@(posedge hclk) disable iff (!rst_n)
        core_ev.exc_entry |=> isb == $past(core_ev.vector_value[0]))
        else $error("state bit not loaded from vector");
    a_branch_load: assert property (@(posedge hclk) disable iff (!rst_n)
        core_ev.xchg_branch && !core_ev.exc_entry && !core_ev.exc_return
        |=> psw[ISB_POS] == $past(core_ev.target_addr[0]))
        else $error("state bit not loaded from target");
    a_return_load: assert property (@(posedge hclk) disable iff (!rst_n)
        core_ev.exc_return && !core_ev.exc_entry
        |=> isb == $past(core_ev.stacked_status_word[ISB_POS]))
        else $error("state bit not restored");
    a_bad_exec: assert property (@(posedge hclk) disable iff (!rst_n)
        core_ev.exec_attempt && !isb |=> core_ans.exec_fault || core_ans.lockup)
        else $error("execution with clear state bit not refused");
    a_reserved_zero: assert property (@(posedge hclk) disable iff (!rst_n)
        psw[23:16] == 8'h00 && psw[9:6] == 4'h0)
        else $error("reserved bits nonzero");
    a_resume_index: assert property (@(posedge hclk) disable iff (!rst_n)
        core_ev.multi_interrupted && !core_ev.exc_return
        |=> psw[IDX_HI:IDX_LO] == $past(core_ev.next_reg_index)
            && psw[11:10] == 2'b00 && psw[26:25] == 2'b00)
        else $error("resume state malformed");
    a_view_split: assert property (@(posedge hclk) disable iff (!rst_n)
        intr_view[31:6] == 26'h0 && exec_view[EXN_HI:EXN_LO] == 6'h00)
        else $error("view carries foreign field");
    a_exn_track: assert property (@(posedge hclk) disable iff (!rst_n)
        core_ev.exc_entry |=> intr_view[EXN_HI:EXN_LO] == $past(core_ev.exc_number)
            && exn_reserved == ($past(core_ev.exc_number) > EXN_IRQ_HI ||
               $past(core_ev.exc_number) == 6'h01))
        else $error("exception number wrong");
    a_block_len: assert property (@(posedge hclk) disable iff (!rst_n)
        cond_left <= COND_BLOCK_MAX[2:0])
        else $error("block longer than four");
    a_isb_hold: assert property (@(posedge hclk) disable iff (!rst_n)
        !core_ev.exc_entry && !core_ev.exc_return && !core_ev.xchg_branch |=> $stable(isb))
        else $error("state bit changed without cause");
    a_exn_return: assert property (@(posedge hclk) disable iff (!rst_n)
        core_ev.exc_return && !core_ev.exc_entry
        |=> exn == $past(core_ev.stacked_status_word[EXN_HI:EXN_LO]))
        else $error("exception number not restored");
    a_resume_valid: assert property (@(posedge hclk) disable iff (!rst_n)
        core_ev.exc_return && core_ev.stacked_status_word[UPR_HI:UPR_LO] == 2'b00
            && core_ev.stacked_status_word[IDX_HI:IDX_LO] != 4'h0
        |=> core_ans.resume_valid
            && core_ans.resume_index == $past(core_ev.stacked_status_word[IDX_HI:IDX_LO]))
        else $error("resume index not handed back");
    a_suspend_flag: assert property (@(posedge hclk) disable iff (!rst_n)
        core_ev.multi_interrupted && !core_ev.exc_return |=> state == ESW_ST_SUSPENDED)
        else $error("suspended transfer not recorded");
    a_cond_open: assert property (@(posedge hclk) disable iff (!rst_n)
        core_ev.cond_block_start && !core_ev.exc_return && !core_ev.multi_interrupted
        |=> cond_left == COND_BLOCK_MAX[2:0] && cstate == $past(core_ev.cond_block_bits))
        else $error("block opener not loaded");
    a_step_clear: assert property (@(posedge hclk) disable iff (!rst_n)
        core_ev.cond_block_step && cond_left == 3'h1 && !core_ev.exc_return
            && !core_ev.multi_interrupted && !core_ev.cond_block_start
        |=> cond_left == 3'h0 && cstate == 8'h00)
        else $error("block not closed after last step");
    a_fault_set: assert property (@(posedge hclk) disable iff (!rst_n)
        bad_exec && !core_ev.in_handler |=> fault)
        else $error("fault flag not set");
    a_lock_set: assert property (@(posedge hclk) disable iff (!rst_n)
        bad_exec && core_ev.in_handler |=> lock)
        else $error("lockup flag not set");
    a_lockup_out: assert property (@(posedge hclk) disable iff (!rst_n)
        lock |=> core_ans.lockup)
        else $error("lockup not reported to core");

    // ----------------------------------------
    // Cover points
    // ----------------------------------------
    c_block: cover property (@(posedge hclk) disable iff (!rst_n)
        core_ev.cond_block_start ##1 cond_left == 3'h4);
    c_suspend: cover property (@(posedge hclk) disable iff (!rst_n)
        state == ESW_ST_SUSPENDED ##[1:20] core_ans.resume_valid);
    c_lock: cover property (@(posedge hclk) disable iff (!rst_n) state == ESW_ST_LOCKUP);
    c_lock_exit: cover property (@(posedge hclk) disable iff (!rst_n)
        state == ESW_ST_LOCKUP ##1 state == ESW_ST_RUN);
    c_reserved: cover property (@(posedge hclk) disable iff (!rst_n) exn_reserved);
endmodule
